// ### logic/slc_lane_cfg.sv
// Lane mux, clock output and fast side PLL configuration registers of one channel.
// Assumes a management frame decoder on clk_sys_i giving index, write pulse and data;
// the power-down and reference choice pins are asynchronous.
//
// Overview of operation
// - Receive ratio 1:2 when select bit is 0, 1:4 when 1; bit resets high.
// - Transmit ratio 2:1 when select bit is 0, 4:1 when 1; bit resets high.
// - Output clock divided per 4-bit code; code 0000 divides by one at reset.
// - Two-bit source field picks which recovered or VCO clock drives the pins.
// - With choice pin low the bit picks reference input zero or one.
// - PLL on bit enables PLL; power-down pin low or power-off bit forces off.
// - Four-bit multiplier code selects 4x to 25x; 20x at reset.
// - PLL control word resets to 0x811D including its reserved bits.
// - Receive one-to-one bit forces 1:1 receive when set; resets clear.
// - Power-off bit shuts the data path but keeps management alive.
`timescale 1ns/1ns
module slc_lane_cfg
  import slc_pkg::*;
(
  input  wire logic                     clk_sys_i,
  input  wire logic                     resetn_i,
  input  wire logic [slc_pkg::ADDR_W-1:0] mgmt_addr_i,
  input  wire logic                     mgmt_wr_i,
  input  wire logic [slc_pkg::DATA_W-1:0] mgmt_wdata_i,
  output logic [slc_pkg::DATA_W-1:0]    mgmt_rdata_o,
  input  wire logic                     channel_power_down_pin_n_i,
  input  wire logic                     reference_choice_pin_i,
  output slc_pkg::slc_ratio_t           rx_ratio_o,
  output slc_pkg::slc_ratio_t           tx_ratio_o,
  output logic [4:0]                    clock_output_divider_o,
  output logic [1:0]                    clock_output_source_o,
  output logic                          reference_input_one_o,
  output logic                          fast_side_pll_on_o,
  output logic [6:0]                    fast_side_pll_mult_x4_o,
  output logic [1:0]                    fast_side_pll_loop_bw_o,
  output logic                          fast_side_vco_low_range_o,
  output logic                          datapath_power_off_o
);
  logic [15:0] lane_d, lane_q, pll_d, pll_q, rdata_d, rdata_q;
  logic [1:0]  pd_sync_d, pd_sync_q, ref_sync_d, ref_sync_q;

  slc_cfg_if cfg_bus ();

  always_comb
  begin
    lane_d     = lane_q;
    pll_d      = pll_q;
    pd_sync_d  = {pd_sync_q[0], channel_power_down_pin_n_i};
    ref_sync_d = {ref_sync_q[0], reference_choice_pin_i};
    if (mgmt_wr_i && mgmt_addr_i == LANE_CTRL_IDX)
      lane_d = mgmt_wdata_i;
    if (mgmt_wr_i && mgmt_addr_i == PLL_CTRL_IDX)
      pll_d = mgmt_wdata_i;
    // Read data is registered, so it reflects the word one cycle after the index
    unique case (mgmt_addr_i)
      LANE_CTRL_IDX: rdata_d = lane_q;
      PLL_CTRL_IDX:  rdata_d = pll_q;
      default:       rdata_d = 16'h0000;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      lane_q     <= LANE_CTRL_RST;
      pll_q      <= PLL_CTRL_RST;
      rdata_q    <= 16'h0000;
      // Power-down pin assumed asserted until seen, so the PLL starts held off
      pd_sync_q  <= 2'b00;
      ref_sync_q <= 2'b00;
    end
    else
    begin
      lane_q     <= lane_d;
      pll_q      <= pll_d;
      rdata_q    <= rdata_d;
      pd_sync_q  <= pd_sync_d;
      ref_sync_q <= ref_sync_d;
    end
  end

  assign mgmt_rdata_o      = rdata_q;
  assign cfg_bus.lane_ctrl = lane_q;
  assign cfg_bus.pll_ctrl  = pll_q;
  assign cfg_bus.pd_pin_n  = pd_sync_q[1];
  assign cfg_bus.ref_pin   = ref_sync_q[1];

  slc_decode u_decode (
    .clk_sys_i                 (clk_sys_i),
    .resetn_i                  (resetn_i),
    .cfg                       (cfg_bus.dec),
    .rx_ratio_o                (rx_ratio_o),
    .tx_ratio_o                (tx_ratio_o),
    .clock_output_divider_o    (clock_output_divider_o),
    .clock_output_source_o     (clock_output_source_o),
    .reference_input_one_o     (reference_input_one_o),
    .fast_side_pll_on_o        (fast_side_pll_on_o),
    .fast_side_pll_mult_x4_o   (fast_side_pll_mult_x4_o),
    .fast_side_pll_loop_bw_o   (fast_side_pll_loop_bw_o),
    .fast_side_vco_low_range_o (fast_side_vco_low_range_o),
    .datapath_power_off_o      (datapath_power_off_o)
  );

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);

  rx_one_mode_a: assert property (lane_q[RX_ONE_BIT] |=> rx_ratio_o == SLC_RATIO_1)
    else $error("receive one-to-one not applied");
  rx_ratio_sel_a: assert property (!lane_q[RX_ONE_BIT] |=>
      rx_ratio_o == ($past(lane_q[RX_SEL_BIT]) ? SLC_RATIO_4 : SLC_RATIO_2))
    else $error("receive ratio does not follow select bit");
  tx_ratio_sel_a: assert property (!lane_q[TX_ONE_BIT] |=>
      tx_ratio_o == ($past(lane_q[TX_SEL_BIT]) ? SLC_RATIO_4 : SLC_RATIO_2))
    else $error("transmit ratio does not follow select bit");
  clk_div_a: assert property (mgmt_wr_i && mgmt_addr_i == LANE_CTRL_IDX
      && mgmt_wdata_i[DIV_LSB +: 4] == 4'hD |-> ##2 clock_output_divider_o == 5'h0A)
    else $error("divide by ten not reached two cycles after write");
  clk_src_a: assert property (##1 clock_output_source_o
      == $past(lane_q[SRC_LSB +: 2]))
    else $error("output clock source mismatch");
  ref_choice_a: assert property (ref_sync_q[1] |=> !reference_input_one_o)
    else $error("reference bit not ignored while pin high");
  pll_force_off_a: assert property (!pd_sync_q[1] || lane_q[PWR_OFF_BIT]
      |=> !fast_side_pll_on_o)
    else $error("PLL not forced off");
  pll_mult_a: assert property (pll_q[MULT_LSB +: 4] == 4'h9
      |=> fast_side_pll_mult_x4_o == 7'h32)
    else $error("12.5x multiplier code misdecoded");
  // Read data trails the stored word by one edge, so a second write may already differ
  pll_word_a: assert property (mgmt_wr_i && mgmt_addr_i == PLL_CTRL_IDX
      |=> pll_q == $past(mgmt_wdata_i)
      ##1 (mgmt_rdata_o == $past(pll_q) || $past(mgmt_addr_i) != PLL_CTRL_IDX))
    else $error("PLL control word not stored");
  pwr_off_a: assert property ($rose(lane_q[PWR_OFF_BIT]) |=> datapath_power_off_o)
    else $error("power-off bit not passed on");
  tx_one_mode_a: assert property (lane_q[TX_ONE_BIT] |=> tx_ratio_o == SLC_RATIO_1)
    else $error("transmit one-to-one not applied");
  rx_sel_low_a: assert property (!lane_q[RX_ONE_BIT] && !lane_q[RX_SEL_BIT]
      |=> rx_ratio_o == SLC_RATIO_2)
    else $error("receive ratio not 1:2 with select low");
  div_one_a: assert property (lane_q[DIV_LSB +: 4] == 4'h0
      |=> clock_output_divider_o == 5'h01)
    else $error("divide by one misdecoded");
  div_five_a: assert property (lane_q[DIV_LSB +: 4] == 4'hC
      |=> clock_output_divider_o == 5'h05)
    else $error("divide by five misdecoded");
  div_max_a: assert property (lane_q[DIV_LSB +: 4] == 4'hF
      |=> clock_output_divider_o == 5'h19)
    else $error("divide by twenty-five misdecoded");
  ref_bit_one_a: assert property (!ref_sync_q[1] && lane_q[REF_BIT]
      |=> reference_input_one_o)
    else $error("reference input one not selected");
  ref_bit_zero_a: assert property (!lane_q[REF_BIT]
      |=> !reference_input_one_o)
    else $error("reference input zero not selected");
  pll_enable_a: assert property (pll_q[PLL_ON_BIT] && pd_sync_q[1]
      && !lane_q[PWR_OFF_BIT] |=> fast_side_pll_on_o)
    else $error("PLL not enabled");
  pll_bit_off_a: assert property (!pll_q[PLL_ON_BIT]
      |=> !fast_side_pll_on_o)
    else $error("PLL enabled with its bit low");
  mult_20x_a: assert property (pll_q[MULT_LSB +: 4] == 4'hD
      |=> fast_side_pll_mult_x4_o == 7'h50)
    else $error("20x multiplier code misdecoded");
  mult_quarter_a: assert property (pll_q[MULT_LSB +: 4] == 4'h6
      |=> fast_side_pll_mult_x4_o == 7'h21)
    else $error("8.25x multiplier code misdecoded");
  mult_4x_a: assert property (pll_q[MULT_LSB +: 4] == 4'h2
      |=> fast_side_pll_mult_x4_o == 7'h10)
    else $error("4x multiplier code misdecoded");
  // Reserved bits live only in the stored word, so holding it guards them too
  pll_hold_a: assert property (!(mgmt_wr_i && mgmt_addr_i == PLL_CTRL_IDX)
      |=> $stable(pll_q))
    else $error("PLL control word changed without a write");
  unmapped_read_a: assert property (mgmt_addr_i != LANE_CTRL_IDX
      && mgmt_addr_i != PLL_CTRL_IDX |=> mgmt_rdata_o == 16'h0000)
    else $error("unmapped index read not zero");
  lane_store_a: assert property (mgmt_wr_i && mgmt_addr_i == LANE_CTRL_IDX
      |=> lane_q == $past(mgmt_wdata_i))
    else $error("lane control word not stored");
  lane_hold_a: assert property (!(mgmt_wr_i && mgmt_addr_i == LANE_CTRL_IDX)
      |=> $stable(lane_q))
    else $error("lane control word changed without a write");
  pwr_off_clear_a: assert property (!lane_q[PWR_OFF_BIT]
      |=> !datapath_power_off_o)
    else $error("power-off shown with bit low");

  // First edge after release: every output still shows its reset value
  rx_ratio_rst_a: assert property (!$past(resetn_i)
      |-> rx_ratio_o == SLC_RATIO_4)
    else $error("receive ratio not 1:4 after reset");
  tx_ratio_rst_a: assert property (!$past(resetn_i)
      |-> tx_ratio_o == SLC_RATIO_4)
    else $error("transmit ratio not 4:1 after reset");
  div_rst_a: assert property (!$past(resetn_i)
      |-> clock_output_divider_o == DIV_RST)
    else $error("divider not one after reset");
  src_rst_a: assert property (!$past(resetn_i)
      |-> clock_output_source_o == LANE_CTRL_RST[SRC_LSB +: 2])
    else $error("output clock source wrong after reset");
  pll_off_rst_a: assert property (!$past(resetn_i)
      |-> !fast_side_pll_on_o)
    else $error("PLL on before the pin is seen");
  mult_rst_a: assert property (!$past(resetn_i)
      |-> fast_side_pll_mult_x4_o == MULT_X4_RST)
    else $error("multiplier not 20x after reset");
  pll_word_rst_a: assert property (!$past(resetn_i)
      |-> pll_q == PLL_CTRL_RST)
    else $error("PLL control word wrong after reset");
  rx_one_rst_a: assert property (!$past(resetn_i)
      |-> !lane_q[RX_ONE_BIT])
    else $error("receive one-to-one set after reset");

  cover_rx_one_c:  cover property (lane_q[RX_ONE_BIT] ##1 rx_ratio_o == SLC_RATIO_1);
  cover_tx_one_c:  cover property (lane_q[TX_ONE_BIT] ##1 tx_ratio_o == SLC_RATIO_1);
  cover_pll_off_c: cover property (fast_side_pll_on_o ##1 !fast_side_pll_on_o);
  cover_ref_one_c: cover property (!reference_input_one_o ##1 reference_input_one_o);
  cover_div25_c:   cover property (clock_output_divider_o == 5'h19);
endmodule : slc_lane_cfg

// ### logic/slc_pkg.sv
// Package for the lane clock and fast side PLL configuration block.
// Assumes a management frame decoder that presents register index and data.
package slc_pkg;
  localparam int unsigned ADDR_W    = 5;
  localparam int unsigned DATA_W    = 16;
  localparam logic [4:0]  LANE_CTRL_IDX = 5'h01;
  localparam logic [4:0]  PLL_CTRL_IDX  = 5'h02;
  localparam logic [15:0] LANE_CTRL_RST = 16'h0300;
  localparam logic [15:0] PLL_CTRL_RST  = 16'h811D;
  // Lane mux and clock output control fields
  localparam int unsigned PWR_OFF_BIT = 15;
  localparam int unsigned RX_ONE_BIT  = 13;
  localparam int unsigned TX_ONE_BIT  = 12;
  localparam int unsigned HYST_LSB    = 10;
  localparam int unsigned RX_SEL_BIT  = 9;
  localparam int unsigned TX_SEL_BIT  = 8;
  localparam int unsigned DIV_LSB     = 4;
  localparam int unsigned SRC_LSB     = 2;
  localparam int unsigned REF_BIT     = 1;
  // Fast side PLL control fields
  localparam int unsigned BW_LSB      = 8;
  localparam int unsigned VRANGE_BIT  = 6;
  localparam int unsigned PLL_ON_BIT  = 4;
  localparam int unsigned MULT_LSB    = 0;
  // Reset state of the decoded outputs, in step with the register resets
  localparam logic [4:0]  DIV_RST     = 5'h01;
  localparam logic [6:0]  MULT_X4_RST = 7'h50;

  typedef enum logic [1:0] {
    SLC_RATIO_1 = 2'b00,
    SLC_RATIO_2 = 2'b01,
    SLC_RATIO_4 = 2'b10
  } slc_ratio_t;
endpackage : slc_pkg

// ### logic/slc_cfg_if.sv
// Carries the stored control words and synchronised pins to the decoder.
// Driven by the register bank, read by the field decoder, one clock.
`timescale 1ns/1ns
interface slc_cfg_if;
  logic [15:0] lane_ctrl;
  logic [15:0] pll_ctrl;
  logic        pd_pin_n;
  logic        ref_pin;
  modport src (output lane_ctrl, output pll_ctrl, output pd_pin_n, output ref_pin);
  modport dec (input lane_ctrl, input pll_ctrl, input pd_pin_n, input ref_pin);
endinterface : slc_cfg_if

// ### logic/slc_decode.sv
// Turns the stored control words into registered controls for the analog blocks.
// Assumes pins in the interface are already synchronised to clk_sys_i.
`timescale 1ns/1ns
module slc_decode
  import slc_pkg::*;
(
  input  wire logic         clk_sys_i,
  input  wire logic         resetn_i,
  slc_cfg_if.dec            cfg,
  output slc_pkg::slc_ratio_t rx_ratio_o,
  output slc_pkg::slc_ratio_t tx_ratio_o,
  output logic [4:0]        clock_output_divider_o,
  output logic [1:0]        clock_output_source_o,
  output logic              reference_input_one_o,
  output logic              fast_side_pll_on_o,
  output logic [6:0]        fast_side_pll_mult_x4_o,
  output logic [1:0]        fast_side_pll_loop_bw_o,
  output logic              fast_side_vco_low_range_o,
  output logic              datapath_power_off_o
);
  slc_ratio_t rx_d, rx_q, tx_d, tx_q;
  logic [4:0] div_d, div_q;
  logic [6:0] mult_d, mult_q;
  logic [1:0] src_d, src_q, bw_d, bw_q;
  logic       ref_d, ref_q, on_d, on_q, vr_d, vr_q, off_d, off_q;

  // Divide ratio; zero marks a reserved code so the clock tree holds off
  function automatic logic [4:0] div_ratio(input logic [3:0] code);
    unique case (code)
      4'h0:    div_ratio = 5'h01;
      4'h6:    div_ratio = 5'h04;
      4'h8:    div_ratio = 5'h08;
      4'hA:    div_ratio = 5'h10;
      4'hC:    div_ratio = 5'h05;
      4'hD:    div_ratio = 5'h0A;
      4'hE:    div_ratio = 5'h14;
      4'hF:    div_ratio = 5'h19;
      default: div_ratio = 5'h00;
    endcase
  endfunction : div_ratio

  // Four times the multiplier keeps the quarter steps integral
  function automatic logic [6:0] mult_x4(input logic [3:0] code);
    unique case (code)
      4'h2:    mult_x4 = 7'h10;
      4'h3:    mult_x4 = 7'h14;
      4'h4:    mult_x4 = 7'h18;
      4'h5:    mult_x4 = 7'h20;
      4'h6:    mult_x4 = 7'h21;
      4'h7:    mult_x4 = 7'h28;
      4'h8:    mult_x4 = 7'h30;
      4'h9:    mult_x4 = 7'h32;
      4'hA:    mult_x4 = 7'h3C;
      4'hB:    mult_x4 = 7'h40;
      4'hC:    mult_x4 = 7'h42;
      4'hD:    mult_x4 = 7'h50;
      4'hE:    mult_x4 = 7'h64;
      default: mult_x4 = 7'h00;
    endcase
  endfunction : mult_x4

  always_comb
  begin
    off_d = cfg.lane_ctrl[PWR_OFF_BIT];
    if (cfg.lane_ctrl[RX_ONE_BIT])
      rx_d = SLC_RATIO_1;
    else
      rx_d = cfg.lane_ctrl[RX_SEL_BIT] ? SLC_RATIO_4 : SLC_RATIO_2;
    if (cfg.lane_ctrl[TX_ONE_BIT])
      tx_d = SLC_RATIO_1;
    else
      tx_d = cfg.lane_ctrl[TX_SEL_BIT] ? SLC_RATIO_4 : SLC_RATIO_2;
    div_d = div_ratio(cfg.lane_ctrl[DIV_LSB +: 4]);
    src_d = cfg.lane_ctrl[SRC_LSB +: 2];
    // With the pin high the pin owns the choice; the bit is ignored
    ref_d = !cfg.ref_pin && cfg.lane_ctrl[REF_BIT];
    on_d  = cfg.pll_ctrl[PLL_ON_BIT] && cfg.pd_pin_n && !off_d;
    mult_d = mult_x4(cfg.pll_ctrl[MULT_LSB +: 4]);
    bw_d  = cfg.pll_ctrl[BW_LSB +: 2];
    vr_d  = cfg.pll_ctrl[VRANGE_BIT];
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      rx_q   <= SLC_RATIO_4;
      tx_q   <= SLC_RATIO_4;
      div_q  <= DIV_RST;
      src_q  <= LANE_CTRL_RST[SRC_LSB +: 2];
      ref_q  <= LANE_CTRL_RST[REF_BIT];
      on_q   <= 1'b0;
      mult_q <= MULT_X4_RST;
      bw_q   <= PLL_CTRL_RST[BW_LSB +: 2];
      vr_q   <= PLL_CTRL_RST[VRANGE_BIT];
      off_q  <= LANE_CTRL_RST[PWR_OFF_BIT];
    end
    else
    begin
      rx_q   <= rx_d;
      tx_q   <= tx_d;
      div_q  <= div_d;
      src_q  <= src_d;
      ref_q  <= ref_d;
      on_q   <= on_d;
      mult_q <= mult_d;
      bw_q   <= bw_d;
      vr_q   <= vr_d;
      off_q  <= off_d;
    end
  end

  assign rx_ratio_o                = rx_q;
  assign tx_ratio_o                = tx_q;
  assign clock_output_divider_o    = div_q;
  assign clock_output_source_o     = src_q;
  assign reference_input_one_o     = ref_q;
  assign fast_side_pll_on_o        = on_q;
  assign fast_side_pll_mult_x4_o   = mult_q;
  assign fast_side_pll_loop_bw_o   = bw_q;
  assign fast_side_vco_low_range_o = vr_q;
  assign datapath_power_off_o      = off_q;
endmodule : slc_decode

// ### tb/slc_lane_cfg_tb.sv
// Self-checking bench for the lane mux, clock output and fast side PLL registers.
// Drives the management port and both pins directly; one clock, no partner model.
`timescale 1ns/1ns
module slc_lane_cfg_tb;
  import slc_pkg::*;
  logic              clk_sys_i = 1'b0;
  logic              resetn_i  = 1'b0;
  logic [ADDR_W-1:0] addr      = '0;
  logic              wr        = 1'b0;
  logic [DATA_W-1:0] wdata     = '0;
  logic              pd_n      = 1'b1;
  logic              ref_pin   = 1'b0;
  logic [DATA_W-1:0] rdata;
  slc_ratio_t        rx_ratio;
  slc_ratio_t        tx_ratio;
  logic [4:0]        div;
  logic [1:0]        src;
  logic [6:0]        mult;
  logic [1:0]        bw;
  logic              ref_one;
  logic              pll_on;
  logic              vrange;
  logic              pwr_off;
  logic [15:0]       lw;
  logic [15:0]       pw;
  logic [4:0]        ua;
  int                err_count   = 0;
  int                comparisons = 0;
  int                cyc         = 0;
  // Divide ratio and four-times multiplier per code; zero marks a reserved code
  localparam logic [4:0] DIV_TAB [16] = '{5'h01, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h04,
    5'h00, 5'h08, 5'h00, 5'h10, 5'h00, 5'h05, 5'h0A, 5'h14, 5'h19};
  localparam logic [6:0] MULT_TAB [16] = '{7'h00, 7'h00, 7'h10, 7'h14, 7'h18, 7'h20, 7'h21,
    7'h28, 7'h30, 7'h32, 7'h3C, 7'h40, 7'h42, 7'h50, 7'h64, 7'h00};
  localparam logic [3:0] DIV_CODES [8] = '{4'h0, 4'h6, 4'h8, 4'hA, 4'hC, 4'hD, 4'hE, 4'hF};

  always #10 clk_sys_i = ~clk_sys_i;

  slc_lane_cfg u_dut (
    .clk_sys_i                  (clk_sys_i),
    .resetn_i                   (resetn_i),
    .mgmt_addr_i                (addr),
    .mgmt_wr_i                  (wr),
    .mgmt_wdata_i               (wdata),
    .mgmt_rdata_o               (rdata),
    .channel_power_down_pin_n_i (pd_n),
    .reference_choice_pin_i     (ref_pin),
    .rx_ratio_o                 (rx_ratio),
    .tx_ratio_o                 (tx_ratio),
    .clock_output_divider_o     (div),
    .clock_output_source_o      (src),
    .reference_input_one_o      (ref_one),
    .fast_side_pll_on_o         (pll_on),
    .fast_side_pll_mult_x4_o    (mult),
    .fast_side_pll_loop_bw_o    (bw),
    .fast_side_vco_low_range_o  (vrange),
    .datapath_power_off_o       (pwr_off)
  );

  function automatic slc_ratio_t ratio_exp(input logic one, input logic sel);
    return one ? SLC_RATIO_1 : (sel ? SLC_RATIO_4 : SLC_RATIO_2);
  endfunction : ratio_exp

  // Software side: only documented divider codes, reserved bits at reset value
  function automatic logic [15:0] lane_legal(input logic [15:0] w);
    return {w[15], 1'b0, w[13:8], DIV_CODES[w[6:4]], w[3:1], 1'b0};
  endfunction : lane_legal

  // Software side: loop bandwidth 01 or 10, no reserved multiplier, reserved bits kept
  function automatic logic [15:0] pll_legal(input logic [15:0] w);
    logic [3:0] mc;
    mc = w[MULT_LSB+:4];
    if (mc < 4'h2 || mc == 4'hF)
      mc = 4'hD;
    return {6'h20, ~w[8], w[8], 1'b0, w[6], 1'b0, w[4], mc};
  endfunction : pll_legal

  task automatic print_verdict();
    $display("comparisons=%0d err_count=%0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic mwr(input logic [4:0] a, input logic [15:0] d);
    @(negedge clk_sys_i);
    addr  = a;
    wdata = d;
    wr    = 1'b1;
    @(negedge clk_sys_i);
    wr = 1'b0;
  endtask : mwr

  // Read data is registered, so it is looked at one edge after the index
  task automatic mrd(input logic [4:0] a, input logic [15:0] e);
    @(negedge clk_sys_i);
    addr = a;
    @(negedge clk_sys_i);
    chk(rdata, e);
  endtask : mrd

  // Waits past the pin synchroniser and decode stage before looking at outputs
  task automatic expect_all(input logic [15:0] l, input logic [15:0] p,
                            input logic pd, input logic rp);
    repeat (4) @(negedge clk_sys_i);
    chk(16'(rx_ratio), 16'(ratio_exp(l[RX_ONE_BIT], l[RX_SEL_BIT])));
    chk(16'(tx_ratio), 16'(ratio_exp(l[TX_ONE_BIT], l[TX_SEL_BIT])));
    chk(16'(div), 16'(DIV_TAB[l[DIV_LSB+:4]]));
    chk(16'(src), 16'(l[SRC_LSB+:2]));
    chk(16'(ref_one), 16'(l[REF_BIT] & ~rp));
    chk(16'(bw), 16'(p[BW_LSB+:2]));
    chk(16'(vrange), 16'(p[VRANGE_BIT]));
    chk(16'(pll_on), 16'(p[PLL_ON_BIT] & pd & ~l[PWR_OFF_BIT]));
    chk(16'(mult), 16'(MULT_TAB[p[MULT_LSB+:4]]));
    chk(16'(pwr_off), 16'(l[PWR_OFF_BIT]));
    mrd(LANE_CTRL_IDX, l);
    mrd(PLL_CTRL_IDX, p);
  endtask : expect_all

  // Both words go in back to back, the strobe held high across two edges
  task automatic apply(input logic [15:0] l, input logic [15:0] p,
                       input logic pd, input logic rp);
    @(negedge clk_sys_i);
    pd_n    = pd;
    ref_pin = rp;
    addr    = LANE_CTRL_IDX;
    wdata   = l;
    wr      = 1'b1;
    @(negedge clk_sys_i);
    addr  = PLL_CTRL_IDX;
    wdata = p;
    @(negedge clk_sys_i);
    wr = 1'b0;
    expect_all(l, p, pd, rp);
  endtask : apply

  task automatic reset_dut();
    @(negedge clk_sys_i);
    resetn_i = 1'b0;
    repeat (20) @(negedge clk_sys_i);
    resetn_i = 1'b1;
    expect_all(LANE_CTRL_RST, PLL_CTRL_RST, pd_n, ref_pin);
  endtask : reset_dut

  always @(posedge clk_sys_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      print_verdict();
    end
  end

  initial
  begin
    void'($urandom(1));
    reset_dut();
    mrd(5'h00, 16'h0000);
    // Every divider, multiplier, source and ratio code, reference pin both ways
    for (int i = 0; i < 16; i++)
      apply(lane_legal({2'b00, i[3], i[2], 2'b00, i[1], i[0], i[3:0], i[1:0], i[0], 1'b0}),
            pll_legal({8'h81, 1'b0, i[0], 1'b0, 1'b1, i[3:0]}), 1'b1, i[1]);
    apply(16'h0300, 16'h811D, 1'b0, 1'b0);
    apply(16'h8300, 16'h811D, 1'b1, 1'b0);
    apply(16'h0300, 16'h810D, 1'b1, 1'b0);
    apply(16'h0300, 16'h811D, 1'b1, 1'b0);
    for (int n = 0; n < 30; n++)
    begin
      lw = lane_legal(16'($urandom));
      pw = pll_legal(16'($urandom));
      apply(lw, pw, 1'($urandom), 1'($urandom));
      ua = 5'($urandom);
      if (ua != LANE_CTRL_IDX && ua != PLL_CTRL_IDX)
      begin
        mwr(ua, ~lw);
        mrd(ua, 16'h0000);
        mrd(LANE_CTRL_IDX, lw);
        mrd(PLL_CTRL_IDX, pw);
      end
    end
    reset_dut();
    print_verdict();
  end
endmodule : slc_lane_cfg_tb
